// >>> hw/ioctc_top.sv
// Purpose: termination and status control of one channel's subchannels
// Assumes: controller signals are levels from another clock domain
// Notes:   one operation active at a time; status stored on stat_wr
`timescale 1ns/1ps
`default_nettype none
module ioctc_top (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  // register port
  input  wire logic [ioctc_pkg::RA_W-1:0]   reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [31:0]                 reg_rdata,
  // descriptor fetch from memory
  output logic                             desc_req,
  output logic      [ioctc_pkg::ADDR_W-1:0] desc_addr,
  input  wire logic                        desc_ack,
  input  wire logic                        desc_err,
  input  wire logic [7:0]                  desc_cmd,
  input  wire logic [ioctc_pkg::ADDR_W-1:0] desc_daddr,
  input  wire logic [ioctc_pkg::CNT_W-1:0]  desc_count,
  input  wire logic                        desc_chain,
  input  wire logic                        eq_fault,
  // controller link
  input  wire logic [ioctc_pkg::CI_N-1:0]   ctl_sig,
  output logic                             ctl_cmd_stb,
  output logic      [7:0]                  ctl_cmd_code,
  output logic      [ioctc_pkg::SUB_W-1:0]  ctl_sub,
  output logic                             ctl_halt,
  output logic                             ctl_data_ack,
  output logic                             ctl_stop,
  output logic                             ctl_disc,
  // status store and interrupt request
  output logic                             stat_wr,
  output logic      [31:0]                 stat_msw,
  output logic      [31:0]                 stat_lsw,
  output logic                             irq_req
);
  import ioctc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CMD, S_XFER, S_WDE} ioctc_state_t;

  function automatic logic sub_hit(input logic [SUB_W-1:0] a, input logic [SUB_W-1:0] b);
    return a == b;
  endfunction : sub_hit

  ioctc_state_t          state_reg, state_next;
  logic [CI_N-1:0]       s1_reg, s2_reg, s3_reg, lvl_reg, lvl_d_reg, ev;
  logic [SUB_W-1:0]      sub_reg;
  logic [ADDR_W-1:0]     cla_reg, daddr_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic                  chain_reg, cont_reg, pchk_reg, cchk_reg, pend_reg;
  logic                  init_reg, burst_reg;
  logic [1:0]            cc_reg;
  logic [15:0]           pbits;
  logic                  post, fetch, issue, cont_set;
  ioctc_chk_if           chk ();

  ioctc_check u_check (.ck(chk));

  assign chk.cmd   = desc_cmd;
  assign chk.daddr = daddr_reg;
  assign chk.count = cnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // controller signal synchroniser; change counts when stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      lvl_reg   <= '0;
      lvl_d_reg <= '0;
    end else begin
      s1_reg    <= ctl_sig;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      lvl_reg   <= (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
      lvl_d_reg <= lvl_reg;
    end
  end
  assign ev = lvl_reg & ~lvl_d_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode
  ioctc_op_t        op;
  logic [SUB_W-1:0] cmd_sub;
  logic             wr_cmd, start_go, rsch, reset_controller_cmd_hit, halt_any, halt_hit, stop_hit;
  logic             malf, clr_pend, busy, unus_now, chain_ok, dack, dstop;

  assign wr_cmd    = reg_wr && (reg_addr == REG_CMD);
  assign op        = ioctc_op_t'(reg_wdata[OP_MSB:OP_LSB]);
  assign cmd_sub   = reg_wdata[SB_MSB:SB_LSB];
  assign busy      = (state_reg == S_CMD) || (state_reg == S_XFER);
  assign start_go  = wr_cmd && (op == OP_START) && (state_reg == S_IDLE)
                     && !pend_reg && init_reg;
  assign rsch      = wr_cmd && (op == OP_RSCH);
  assign reset_controller_cmd_hit = wr_cmd && (op == OP_RESET_CONTROLLER_CMD) && sub_hit(cmd_sub, sub_reg)
                     && (state_reg != S_IDLE);
  assign halt_any  = wr_cmd && (op == OP_HALT);
  assign halt_hit  = halt_any && sub_hit(cmd_sub, sub_reg) && busy;
  assign stop_hit  = wr_cmd && (op == OP_STOP) && sub_hit(cmd_sub, sub_reg);
  assign malf      = (eq_fault || ev[CI_BAD]) && (state_reg != S_IDLE);
  assign clr_pend  = wr_cmd && ((op == OP_ACK) || (op == OP_TEST) || (op == OP_START));
  assign unus_now  = pchk_reg || cchk_reg || ev[CI_UC] || ev[CI_UX];
  assign chain_ok  = chain_reg && !unus_now;
  // stop is only ever given as the answer to a data request
  assign dack      = (state_reg == S_XFER) && ev[CI_DREQ] && !rsch && !reset_controller_cmd_hit && !malf;
  assign dstop     = (cnt_reg == '0) || pchk_reg || cchk_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // termination sequencing
  always_comb begin
    state_next = state_reg;
    post       = 1'b0;
    pbits      = '0;
    fetch      = 1'b0;
    issue      = 1'b0;
    cont_set   = 1'b0;
    case (state_reg)
      S_IDLE: if (start_go) begin
        state_next = S_FETCH;
        fetch      = 1'b1;
      end
      S_FETCH: if (desc_ack) begin
        if (desc_err || chk.bad_cmd) begin
          post       = 1'b1;
          pbits[ST_CCHK] = desc_err;
          pbits[ST_PCHK] = !desc_err;
          state_next = S_IDLE;
        end else begin
          state_next = S_CMD;
          issue      = 1'b1;
        end
      end
      S_CMD: if (ev[CI_REJ] || ev[CI_UC] || ev[CI_UX]) begin
        post         = 1'b1;
        pbits[ST_UC] = ev[CI_REJ] || ev[CI_UC];
        pbits[ST_UX] = ev[CI_UX];
        state_next   = S_IDLE;
      end else if (ev[CI_DE]) begin
        if (chain_reg) begin
          state_next = S_FETCH;
          fetch      = 1'b1;
        end else begin
          post         = 1'b1;
          pbits[ST_CE] = 1'b1;
          pbits[ST_DE] = 1'b1;
          state_next   = S_IDLE;
        end
      end else if (ev[CI_ACC]) begin
        state_next = S_XFER;
      end
      S_XFER: if ((ev[CI_UC] || ev[CI_UX]) && (ev[CI_DE] || ev[CI_CTE])) begin
        // channel end is withheld from software here
        post          = 1'b1;
        pbits[ST_UC]  = ev[CI_UC];
        pbits[ST_UX]  = ev[CI_UX];
        pbits[ST_DE]  = ev[CI_DE];
        pbits[ST_CTE] = ev[CI_CTE];
        state_next    = S_IDLE;
      end else if (ev[CI_CE]) begin
        if (chain_ok) begin
          cont_set = 1'b1;
          if (ev[CI_DE]) begin
            state_next = S_FETCH;
            fetch      = 1'b1;
          end else begin
            state_next = S_WDE;
          end
        end else begin
          post           = 1'b1;
          pbits[ST_CE]   = 1'b1;
          pbits[ST_DE]   = ev[CI_DE];
          pbits[ST_ILEN] = (cnt_reg != '0);
          pbits[ST_PCHK] = pchk_reg;
          pbits[ST_CCHK] = cchk_reg;
          pbits[ST_UC]   = ev[CI_UC];
          pbits[ST_UX]   = ev[CI_UX];
          state_next     = ev[CI_DE] ? S_IDLE : S_WDE;
        end
      end
      S_WDE: if (ev[CI_DE]) begin
        if (cont_reg && chain_reg) begin
          state_next = S_FETCH;
          fetch      = 1'b1;
        end else begin
          post         = 1'b1;
          pbits[ST_DE] = 1'b1;
          pbits[ST_UC] = ev[CI_UC];
          pbits[ST_UX] = ev[CI_UX];
          state_next   = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
    if (rsch || reset_controller_cmd_hit) begin
      state_next = S_IDLE;
      post       = 1'b0;
      pbits      = '0;
      fetch      = 1'b0;
      issue      = 1'b0;
      cont_set   = 1'b0;
    end else if (malf) begin
      state_next      = S_IDLE;
      post            = 1'b1;
      pbits           = '0;
      pbits[ST_CTLCK] = eq_fault;
      pbits[ST_IFCK]  = !eq_fault;
      fetch           = 1'b0;
      issue           = 1'b0;
      cont_set        = 1'b0;
    end else if (halt_hit) begin
      state_next = S_WDE;
      post       = 1'b0;
      pbits      = '0;
      issue      = 1'b0;
      cont_set   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) state_reg <= S_IDLE;
    else        state_reg <= state_next;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)                     cont_reg <= 1'b0;
    else if (cont_set)              cont_reg <= 1'b1;
    else if (state_next != S_WDE)   cont_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // operation context
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sub_reg   <= '0;
      desc_addr <= '0;
      daddr_reg <= '0;
      cnt_reg   <= '0;
      chain_reg <= 1'b0;
    end else begin
      if (start_go) begin
        sub_reg   <= cmd_sub;
        desc_addr <= cla_reg;
      end else if (fetch) begin
        desc_addr <= desc_addr + DESC_STEP;
      end
      if (state_reg == S_FETCH && desc_ack) begin
        daddr_reg <= desc_daddr;
        cnt_reg   <= desc_count;
      end else if (dack && !dstop) begin
        cnt_reg   <= cnt_reg - CNT_W'(1);
      end
      // stop wins over a descriptor load in the same cycle
      if (stop_hit || rsch)                    chain_reg <= 1'b0;
      else if (state_reg == S_FETCH && desc_ack) chain_reg <= desc_chain;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pchk_reg <= 1'b0;
      cchk_reg <= 1'b0;
    end else if (issue || state_next == S_IDLE) begin
      pchk_reg <= 1'b0;
      cchk_reg <= 1'b0;
    end else begin
      // address checked only once data will move; immediate ops skip it
      if (state_reg == S_CMD && ev[CI_ACC] && chk.bad_addr) pchk_reg <= 1'b1;
      if (state_reg == S_XFER && desc_err)                 cchk_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // controller and memory outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      desc_req     <= 1'b0;
      ctl_cmd_stb  <= 1'b0;
      ctl_cmd_code <= '0;
      ctl_sub      <= '0;
      ctl_halt     <= 1'b0;
      ctl_data_ack <= 1'b0;
      ctl_stop     <= 1'b0;
      ctl_disc     <= 1'b1;
    end else begin
      if (fetch)                                     desc_req <= 1'b1;
      else if (desc_ack || state_next == S_IDLE)     desc_req <= 1'b0;
      ctl_cmd_stb  <= issue;
      if (issue) ctl_cmd_code <= desc_cmd;
      if (halt_any)   ctl_sub <= cmd_sub;
      else if (issue) ctl_sub <= sub_reg;
      ctl_halt     <= halt_any;
      ctl_data_ack <= dack;
      ctl_stop     <= dack && dstop;
      ctl_disc     <= malf || ((rsch || reset_controller_cmd_hit) && burst_reg
                      && state_reg == S_XFER);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stat_wr  <= 1'b0;
      stat_msw <= '0;
      stat_lsw <= '0;
      irq_req  <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      stat_wr <= post;
      irq_req <= post;
      if (post) begin
        stat_msw <= {sub_reg, desc_addr + DESC_STEP};
        stat_lsw <= {pbits, cnt_reg};
      end
      // a new posting wins over a clear in the same cycle
      if (post)                 pend_reg <= 1'b1;
      else if (clr_pend || rsch) pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      init_reg  <= 1'b0;
      burst_reg <= 1'b0;
      cla_reg   <= '0;
      cc_reg    <= CC_OK;
    end else begin
      if (rsch) begin
        init_reg  <= 1'b0;
        burst_reg <= 1'b0;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
        init_reg  <= reg_wdata[CT_INIT];
        burst_reg <= reg_wdata[CT_BURST];
      end
      if (reg_wr && reg_addr == REG_CLA) cla_reg <= reg_wdata[ADDR_W-1:0];
      if (wr_cmd && op == OP_START) begin
        if (!init_reg)                 cc_reg <= CC_NOINIT;
        else if (pend_reg)             cc_reg <= CC_STORED;
        else if (state_reg != S_IDLE)  cc_reg <= CC_BUSY;
        else                           cc_reg <= CC_OK;
      end else if (wr_cmd && op == OP_TEST) begin
        cc_reg <= pend_reg ? CC_STORED : (state_reg != S_IDLE ? CC_BUSY : CC_OK);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {30'h0000_0000, init_reg, burst_reg};
        REG_CLA:  reg_rdata <= {8'h00, cla_reg};
        REG_STAT: reg_rdata <= 32'({cc_reg, sub_reg, pend_reg, 1'b0, state_reg});
        default:  reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_stop_on_request: assert property (ctl_stop |-> ctl_data_ack && $past(lvl_reg[CI_DREQ]))
    else $error("stop given without a data request");
  a_stop_zero_count: assert property (state_reg == S_XFER && ev[CI_DREQ] && cnt_reg == '0
    && !malf && !rsch && !reset_controller_cmd_hit |=> ctl_stop)
    else $error("zero count not stopped");
  a_start_blocked: assert property (pend_reg && wr_cmd && op == OP_START
    |=> state_reg == S_IDLE && !pend_reg)
    else $error("start accepted while condition pending");
  a_rsch_quiet: assert property (rsch |=> state_reg == S_IDLE && !irq_req && !init_reg
    ##1 !irq_req)
    else $error("channel reset not quiet");
  a_halt_forward: assert property (halt_any |=> ctl_halt && ctl_sub == $past(cmd_sub))
    else $error("halt not forwarded");
  a_stop_chain: assert property (stop_hit |=> !chain_reg && !ctl_cmd_stb)
    else $error("stop left chaining set");
  a_malf_disc: assert property (malf && !rsch && !reset_controller_cmd_hit
    |=> ctl_disc && stat_wr && (stat_lsw[CNT_W+ST_CTLCK] || stat_lsw[CNT_W+ST_IFCK]))
    else $error("malfunction not reported");
  a_imm_no_len: assert property (state_reg == S_CMD && ev[CI_DE] && !chain_reg
    && !ev[CI_REJ] && !ev[CI_UC] && !ev[CI_UX] && !malf && !rsch && !reset_controller_cmd_hit
    |=> stat_wr && !stat_lsw[CNT_W+ST_ILEN])
    else $error("immediate op reported length");
  a_uc_hides_ce: assert property (state_reg == S_XFER && ev[CI_UC] && ev[CI_DE]
    && !malf && !rsch && !reset_controller_cmd_hit |=> stat_wr && !stat_lsw[CNT_W+ST_CE])
    else $error("channel end shown with unit check");
  a_chain_silent: assert property (state_reg == S_XFER && ev[CI_CE] && ev[CI_DE] && chain_ok
    && !malf && !rsch && !reset_controller_cmd_hit && !halt_hit |=> !stat_wr ##1 desc_req)
    else $error("chained ending interrupted");
  a_irq_once: assert property (irq_req |=> !irq_req)
    else $error("interrupt alerted twice");

  c_chain: cover property (state_reg == S_WDE && cont_reg ##[1:50] state_reg == S_FETCH);
  c_stop: cover property (ctl_stop);
  c_reject: cover property (state_reg == S_CMD && ev[CI_REJ]);
  c_halt: cover property (halt_hit ##[1:50] stat_wr);
endmodule : ioctc_top
`default_nettype wire

// >>> hw/ioctc_pkg.sv
// Purpose: constants for the subchannel termination controller
// Assumes: 32-bit register port, one active subchannel at a time
// Notes:   status bit indices count from the lsb of the 16-bit field
package ioctc_pkg;
  localparam int SUB_W  = 8;
  localparam int ADDR_W = 24;
  localparam int CNT_W  = 16;
  localparam int RA_W   = 4;
  localparam logic [ADDR_W-1:0] DESC_STEP = 24'h00_0008;
  // register offsets
  localparam logic [RA_W-1:0] REG_CMD  = 4'h0;
  localparam logic [RA_W-1:0] REG_CTRL = 4'h4;
  localparam logic [RA_W-1:0] REG_CLA  = 4'h8;
  localparam logic [RA_W-1:0] REG_STAT = 4'hc;
  localparam int OP_LSB = 0;
  localparam int OP_MSB = 2;
  localparam int SB_LSB = 8;
  localparam int SB_MSB = 15;
  localparam int CT_BURST = 0;
  localparam int CT_INIT  = 1;
  localparam int RS_PEND  = 4;
  localparam int RS_CC    = 8;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_START = 3'h1, OP_TEST = 3'h2, OP_HALT = 3'h3,
    OP_RSCH = 3'h4, OP_RESET_CONTROLLER_CMD = 3'h5, OP_STOP = 3'h6, OP_ACK = 3'h7
  } ioctc_op_t;
  localparam logic [1:0] CC_OK     = 2'h0;
  localparam logic [1:0] CC_STORED = 2'h1;
  localparam logic [1:0] CC_BUSY   = 2'h2;
  localparam logic [1:0] CC_NOINIT = 2'h3;
  // controller signal indices
  localparam int CI_ACC  = 0;
  localparam int CI_REJ  = 1;
  localparam int CI_CE   = 2;
  localparam int CI_DE   = 3;
  localparam int CI_UC   = 4;
  localparam int CI_UX   = 5;
  localparam int CI_DREQ = 6;
  localparam int CI_BAD  = 7;
  localparam int CI_CTE  = 8;
  localparam int CI_N    = 9;
  // status bits
  localparam int ST_ILEN  = 13;
  localparam int ST_PCHK  = 12;
  localparam int ST_CCHK  = 11;
  localparam int ST_CTLCK = 10;
  localparam int ST_IFCK  = 9;
  localparam int ST_CE    = 5;
  localparam int ST_CTE   = 4;
  localparam int ST_DE    = 3;
  localparam int ST_UC    = 1;
  localparam int ST_UX    = 0;
endpackage : ioctc_pkg

// >>> hw/ioctc_chk_if.sv
// Purpose: carries descriptor fields to the validity checker
// Assumes: checker is combinational
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface ioctc_chk_if;
  logic [7:0]                  cmd;
  logic [ioctc_pkg::ADDR_W-1:0] daddr;
  logic [ioctc_pkg::CNT_W-1:0]  count;
  logic                        bad_cmd;
  logic                        bad_addr;
  modport ctrl (output cmd, output daddr, output count, input bad_cmd, input bad_addr);
  modport chk  (input cmd, input daddr, input count, output bad_cmd, output bad_addr);
endinterface : ioctc_chk_if
`default_nettype wire

// >>> hw/ioctc_check.sv
// Purpose: validity checks on software-supplied descriptor fields
// Assumes: command code with zero low nibble is invalid
// Notes:   address check is requested only for a data transfer
`timescale 1ns/1ps
`default_nettype none
module ioctc_check (
  // descriptor fields and verdicts
  ioctc_chk_if.chk ck
);
  import ioctc_pkg::*;
  assign ck.bad_cmd  = (ck.cmd[3:0] == 4'h0);
  // a zero address only matters when bytes are to move
  assign ck.bad_addr = (ck.count != '0) && (ck.daddr == '0);
endmodule : ioctc_check
`default_nettype wire

// >>> tb/ioctc_ctl_model.sv
// Purpose: behavioural device controller on the far side of the block
// Assumes: levels held 4 cycles, low 4 cycles between events
// Notes:   reject, immediate or full data run, chosen per command by the bench
`timescale 1ns/1ps
`default_nettype none
module ioctc_ctl_model (
  // clock
  input  wire logic                      mclk,
  // from the block
  input  wire logic                      ctl_cmd_stb,
  input  wire logic                      ctl_halt,
  // scenario control
  input  wire logic                      rej,
  input  wire logic [3:0]                nreq,
  // to the block
  output logic      [ioctc_pkg::CI_N-1:0] ctl_sig
);
  import ioctc_pkg::*;
  localparam logic [CI_N-1:0] B1 = 9'h001;
  int issued = 0, served = 0, halts = 0, halted = 0;
  initial ctl_sig = '0;
  // strobes are counted apart so none is lost while a hold runs
  always @(posedge mclk) begin
    if (ctl_cmd_stb === 1'b1) issued <= issued + 1;
    if (ctl_halt === 1'b1) halts <= halts + 1;
  end
  task automatic hold(input logic [CI_N-1:0] m);
    ctl_sig <= m;
    repeat (4) @(posedge mclk);
    ctl_sig <= '0;
    repeat (4) @(posedge mclk);
  endtask : hold
  always begin
    @(posedge mclk);
    if (issued != served) begin
      served++;
      if (rej) begin
        hold(B1 << CI_REJ);
      end else if (nreq == 4'h0) begin
        hold((B1 << CI_CE) | (B1 << CI_DE));
      end else begin
        hold(B1 << CI_ACC);
        repeat (nreq) hold(B1 << CI_DREQ);
        hold((B1 << CI_CE) | (B1 << CI_DE));
      end
    end else if (halts != halted) begin
      halted++;
      hold(B1 << CI_DE);
    end
  end
endmodule : ioctc_ctl_model
`default_nettype wire

// >>> tb/tb_ioctc_top.sv
// Purpose: self-checking bench for the termination controller
// Assumes: one subchannel in use, descriptors answered one cycle late
// Notes:   rows cover normal, immediate, reject, program check, stop and chained ends
`timescale 1ns/1ps
`default_nettype none
module tb_ioctc_top;
  import ioctc_pkg::*;
  typedef struct packed {
    logic rej; logic [3:0] nreq; logic [15:0] cnt; logic [7:0] cmd; logic [15:0] st;
    logic chn; logic [31:0] ms; logic [11:0] ex;
  } ioctc_row_t;
  // ex: expected {command issues, data acks, stop answers}
  localparam ioctc_row_t ROWS [6] = '{
    '{1'b0, 4'h3, 16'h0003, 8'h01, 16'h0028, 1'b0, 32'h0500_0108, 12'h130},
    '{1'b0, 4'h0, 16'h0000, 8'h03, 16'h0028, 1'b0, 32'h0500_0108, 12'h100},
    '{1'b1, 4'h0, 16'h0000, 8'h01, 16'h0002, 1'b0, 32'h0500_0108, 12'h100},
    '{1'b0, 4'h0, 16'h0000, 8'h00, 16'h1000, 1'b0, 32'h0500_0108, 12'h000},
    '{1'b0, 4'h2, 16'h0001, 8'h01, 16'h0028, 1'b0, 32'h0500_0108, 12'h121},
    '{1'b0, 4'h1, 16'h0001, 8'h01, 16'h0028, 1'b1, 32'h0500_0110, 12'h220}};
  logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, desc_ack = 0, rej = 0;
  logic chn = 0, eq_fault = 0;
  logic [15:0] code;
  logic [3:0] reg_addr = '0, nreq = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, stat_msw, stat_lsw, msw, lsw, d;
  logic [ADDR_W-1:0] desc_addr;
  logic [CNT_W-1:0] cnt = '0;
  logic [7:0] cmd = '0, ctl_cmd_code;
  logic [CI_N-1:0] ctl_sig;
  logic [SUB_W-1:0] ctl_sub;
  logic desc_req, ctl_cmd_stb, ctl_halt, ctl_data_ack, ctl_stop, ctl_disc, stat_wr, irq_req;
  int miscompares = 0, compares = 0, posts = 0, irqs = 0, cyc = 0, p0;
  int issues = 0, acks = 0, stops = 0, discs = 0, i0, a0, s0, d0;
  always #5 mclk = ~mclk;
  ioctc_top uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_req(desc_req),
    .desc_addr(desc_addr), .desc_ack(desc_ack), .desc_err(1'b0), .desc_cmd(cmd),
    .desc_daddr(24'h00_0200), .desc_count(cnt), .desc_chain(chn && desc_addr == 24'h00_0100),
    .eq_fault(eq_fault),
    .ctl_sig(ctl_sig), .ctl_cmd_stb(ctl_cmd_stb), .ctl_cmd_code(ctl_cmd_code),
    .ctl_sub(ctl_sub), .ctl_halt(ctl_halt), .ctl_data_ack(ctl_data_ack), .ctl_stop(ctl_stop),
    .ctl_disc(ctl_disc), .stat_wr(stat_wr), .stat_msw(stat_msw), .stat_lsw(stat_lsw),
    .irq_req(irq_req));
  ioctc_ctl_model ctl (.mclk(mclk), .ctl_cmd_stb(ctl_cmd_stb), .ctl_halt(ctl_halt),
    .rej(rej), .nreq(nreq), .ctl_sig(ctl_sig));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    desc_ack <= desc_req === 1'b1 && !desc_ack;
    if (stat_wr === 1'b1) begin
      posts <= posts + 1;
      lsw <= stat_lsw;
      msw <= stat_msw;
    end
    if (irq_req === 1'b1) irqs <= irqs + 1;
    if (ctl_cmd_stb === 1'b1) begin
      issues <= issues + 1;
      code   <= {ctl_sub, ctl_cmd_code};
    end
    if (ctl_data_ack === 1'b1) acks <= acks + 1;
    if (ctl_stop === 1'b1) stops <= stops + 1;
    if (ctl_disc === 1'b1) discs <= discs + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic cmd_op(input logic [2:0] op);
    wr(REG_CMD, {16'h0000, 8'h05, 5'h00, op});
  endtask : cmd_op
  task automatic complete_run();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge mclk);
    chk({31'h0, ctl_disc}, 32'h0000_0001);
    rst_b <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(REG_CTRL, 32'h0000_0002);
    wr(REG_CLA, 32'h0000_0100);
    for (int i = 0; i < 6; i++) begin
      {rej, nreq, cnt, cmd, chn} <= {ROWS[i].rej, ROWS[i].nreq, ROWS[i].cnt, ROWS[i].cmd,
        ROWS[i].chn};
      p0 = posts;
      i0 = issues;
      a0 = acks;
      s0 = stops;
      cmd_op(OP_START);
      for (int k = 0; k < 400 && posts == p0; k++) @(posedge mclk);
      chk(lsw, {ROWS[i].st, 16'h0000});
      chk(msw, ROWS[i].ms);
      repeat (3) @(posedge mclk);
      chk(irqs, posts);
      chk({20'h0_0000, 4'(issues - i0), 4'(acks - a0), 4'(stops - s0)},
        {20'h0_0000, ROWS[i].ex});
      if (ROWS[i].ex[11:8] != 4'h0) chk({16'h0000, code}, {16'h0000, 8'h05, ROWS[i].cmd});
      cmd_op(OP_ACK);
      repeat (40) @(posedge mclk);
      $display("row %0d done", i);
    end
    // malfunction while waiting for the controller, then a start that must stay blocked
    {rej, nreq, cnt, cmd, chn} <= {1'b0, 4'h0, 16'h0000, 8'h01, 1'b0};
    p0 = posts;
    d0 = discs;
    cmd_op(OP_START);
    repeat (4) @(posedge mclk);
    eq_fault <= 1'b1;
    @(posedge mclk);
    eq_fault <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(posts - p0, 1);
    chk(lsw, {16'h0400, 16'h0000});
    chk(discs - d0, 1);
    i0 = issues;
    cmd_op(OP_START);
    repeat (20) @(posedge mclk);
    chk(issues - i0, 0);
    $display("malfunction test done");
    p0 = posts;
    cmd_op(OP_RSCH);
    cmd_op(OP_START);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= REG_STAT;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk({30'h0, d[14:13]}, {30'h0, CC_NOINIT});
    repeat (20) @(posedge mclk);
    chk(posts, p0);
    $display("reset channel test done");
    complete_run();
  end
endmodule : tb_ioctc_top
`default_nettype wire
